// ==== xte_pkg.sv ====
/*
 Constants, register layout and state encodings of the transfer engine.
 Assumes a byte-wide register port decoded on the low address byte.
*/
package xte_pkg;
   // Register map: eight subchannels, eight bytes each
   localparam logic [7:0] REG_BASE = 8'h20;
   localparam logic [7:0] REG_END = 8'h60;
   localparam logic [2:0] OFS_ADDR_R = 3'h0;
   localparam logic [2:0] OFS_ADDR_E = 3'h1;
   localparam logic [2:0] OFS_ADDR_H = 3'h2;
   localparam logic [2:0] OFS_ADDR_L = 3'h3;
   localparam logic [2:0] OFS_CNT_H = 3'h4;
   localparam logic [2:0] OFS_CNT_L = 3'h5;
   localparam logic [2:0] OFS_IO = 3'h6;
   localparam logic [2:0] OFS_CTRL = 3'h7;
   // Control byte fields
   localparam int CTL_EN = 7;
   localparam int CTL_WORD = 6;
   localparam int CTL_DEC = 5;
   localparam int CTL_FULL = 4;
   localparam int CTL_FIXDST = 4;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_SRC_LO = 0;
   // Mode field values
   localparam logic [1:0] MODE_IO = 2'h0;
   localparam logic [1:0] MODE_IDLE = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_BLOCK = 2'h1;
   // Request source field values
   localparam logic [1:0] SRC_TIMER = 2'h0;
   localparam logic [1:0] SRC_TXE = 2'h1;
   localparam logic [1:0] SRC_RXF = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [1:0] SRC_AUTO_CS = 2'h1;
   localparam logic [1:0] SRC_AUTO_BURST = 2'h2;
   // Short-mode I/O page and reset values
   localparam logic [15:0] IO_PAGE = 16'hFFFF;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0] IO_RST = 8'h00;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [7:0] CNT8_ONE = 8'h01;
   localparam logic [3:0] EXT_IDLE = 4'hF;
   // Engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_READ = 2'b10,
      ST_WRITE = 2'b11
   } xte_state_t;
endpackage : xte_pkg

// ==== xte_prio.sv ====
/*
 Fixed-priority selector over the eight subchannel requests.
 Assumes requests are registered pending bits on the engine clock.
*/
`timescale 1ns/100ps
module xte_prio (
   // Pending requests
   input wire logic [7:0] req_i,
   // Winner
   output logic [2:0] idx_o,
   output logic valid_o
);
   always_comb
   begin
      idx_o = 3'h0;
      valid_o = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         if (req_i[i])
         begin
            idx_o = 3'(i);
            valid_o = 1'b1;
         end
      end
   end
endmodule : xte_prio

// ==== xte_transfer_engine.sv ====
/*
 Eight-subchannel transfer engine with short and full address modes.
 Assumes a bus slave answering each cycle with a one-cycle bus_ack_i,
 timer and serial events as one-cycle pulses on mclk_i.
*/
`timescale 1ns/100ps
module xte_transfer_engine (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Request sources
   input wire logic [3:0] tmr_match_i,
   input wire logic sci_tx_empty_i,
   input wire logic sci_rx_full_i,
   input wire logic [3:0] ext_xfer_request_b_i,
   // Transfer end pins
   output logic [3:0] xfer_end_flag_out_b_o,
   // System bus master
   output logic bus_req_o,
   output logic bus_wr_o,
   output logic bus_word_o,
   output logic bus_hold_o,
   output logic [23:0] bus_addr_o,
   output logic [15:0] bus_wdata_o,
   input wire logic [15:0] bus_rdata_i,
   input wire logic bus_ack_i
);
   logic [23:0] maddr_r [8];
   logic [23:0] mbase_r [8];
   logic [7:0] ioaddr_r [8];
   logic [15:0] count_r [8];
   logic [7:0] ctrl_r [8];
   logic [7:0] pend_r;
   logic [7:0] req;
   logic [3:0] ext_s1_r;
   logic [3:0] ext_s2_r;
   logic [3:0] ext_s3_r;
   logic [3:0] ext_fall;
   logic [2:0] cur_r;
   logic [2:0] grant;
   logic grant_valid;
   xte_pkg::xte_state_t state_r;
   xte_pkg::xte_state_t state_nxt;
   logic [7:0] off;
   logic hit;
   logic [2:0] ca;
   logic [2:0] cb;
   logic full_c;
   logic [1:0] mode_c;
   logic auto_c;
   logic burst_c;
   logic mem_to_io;
   logic [23:0] src_addr;
   logic [23:0] dst_addr;
   logic unit_done;
   logic last_s;
   logic blk_last;
   logic chan_end;
   logic blk_more;
   logic cont;
   logic en_clr;

   function automatic logic [23:0] step_addr(input logic [23:0] a,
                                             input logic word,
                                             input logic dec);
      logic [23:0] d;
      d = word ? 24'h000002 : 24'h000001;
      step_addr = dec ? a - d : a + d;
   endfunction : step_addr

   function automatic logic [1:0] mode_of(input logic [7:0] c);
      mode_of = c[xte_pkg::CTL_MODE_LO +: 2];
   endfunction : mode_of

   // Register decode
   assign off = reg_addr_i - xte_pkg::REG_BASE;
   assign hit = (reg_addr_i >= xte_pkg::REG_BASE) &&
                (reg_addr_i < xte_pkg::REG_END);

   // External request pins: two-stage sync, then falling edge
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ext_s1_r <= xte_pkg::EXT_IDLE;
         ext_s2_r <= xte_pkg::EXT_IDLE;
         ext_s3_r <= xte_pkg::EXT_IDLE;
      end
      else
      begin
         ext_s1_r <= ext_xfer_request_b_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end
   assign ext_fall = ext_s3_r & ~ext_s2_r;

   // Request events per subchannel
   always_comb
   begin
      logic f;
      logic [1:0] sel;
      logic ev;
      f = 1'b0;
      sel = 2'h0;
      ev = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         f = ctrl_r[2 * (i / 2)][xte_pkg::CTL_FULL];
         sel = ctrl_r[i][xte_pkg::CTL_SRC_LO +: 2];
         ev = 1'b0;
         if (!f)
         begin
            case (sel)
               xte_pkg::SRC_TIMER: ev = tmr_match_i[i / 2];
               xte_pkg::SRC_TXE: ev = sci_tx_empty_i;
               xte_pkg::SRC_RXF: ev = sci_rx_full_i;
               default: ev = (i % 2 == 1) && ext_fall[i / 2];
            endcase
         end
         else if (i % 2 == 0)
         begin
            if (mode_of(ctrl_r[i]) == xte_pkg::MODE_BLOCK)
               ev = (sel == xte_pkg::SRC_TIMER) ? tmr_match_i[i / 2] :
                    (sel == xte_pkg::SRC_EXT) ? ext_fall[i / 2] : 1'b0;
            else
               ev = (sel == xte_pkg::SRC_EXT) ? ext_fall[i / 2] :
                    (sel != xte_pkg::SRC_TIMER);
         end
         req[i] = ctrl_r[i][xte_pkg::CTL_EN] && ev &&
                  !(en_clr && cur_r == 3'(i));
      end
   end

   xte_prio u_prio (
      .req_i(pend_r),
      .idx_o(grant),
      .valid_o(grant_valid)
   );

   // Current subchannel decode
   always_comb
   begin
      ca = {cur_r[2:1], 1'b0};
      cb = {cur_r[2:1], 1'b1};
      full_c = ctrl_r[ca][xte_pkg::CTL_FULL];
      mode_c = mode_of(ctrl_r[full_c ? ca : cur_r]);
      auto_c = full_c && (mode_c == xte_pkg::MODE_NORMAL) &&
               (ctrl_r[ca][1:0] == xte_pkg::SRC_AUTO_CS ||
                ctrl_r[ca][1:0] == xte_pkg::SRC_AUTO_BURST);
      burst_c = ctrl_r[ca][1:0] == xte_pkg::SRC_AUTO_BURST;
      mem_to_io = ctrl_r[cur_r][1:0] != xte_pkg::SRC_RXF;
      if (full_c)
      begin
         src_addr = maddr_r[ca];
         dst_addr = maddr_r[cb];
      end
      else if (mem_to_io)
      begin
         src_addr = maddr_r[cur_r];
         dst_addr = {xte_pkg::IO_PAGE, ioaddr_r[cur_r]};
      end
      else
      begin
         src_addr = {xte_pkg::IO_PAGE, ioaddr_r[cur_r]};
         dst_addr = maddr_r[cur_r];
      end
      unit_done = (state_r == xte_pkg::ST_WRITE) && bus_ack_i;
      last_s = (mode_c == xte_pkg::MODE_REPEAT) ?
               count_r[cur_r][7:0] == xte_pkg::CNT8_ONE :
               count_r[cur_r] == xte_pkg::CNT_ONE;
      blk_last = count_r[ca][7:0] == xte_pkg::CNT8_ONE;
      blk_more = full_c && (mode_c == xte_pkg::MODE_BLOCK) && !blk_last;
      if (!full_c)
         chan_end = last_s;
      else if (mode_c == xte_pkg::MODE_BLOCK)
         chan_end = blk_last && count_r[cb] == xte_pkg::CNT_ONE;
      else
         chan_end = count_r[ca] == xte_pkg::CNT_ONE;
      cont = blk_more || (auto_c && burst_c && !chan_end);
      en_clr = unit_done && chan_end &&
               (full_c || mode_c != xte_pkg::MODE_REPEAT);
   end

   // Next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         xte_pkg::ST_IDLE:
            if (grant_valid)
               state_nxt = xte_pkg::ST_LOAD;
         xte_pkg::ST_LOAD:
            state_nxt = xte_pkg::ST_READ;
         xte_pkg::ST_READ:
            if (bus_ack_i)
               state_nxt = xte_pkg::ST_WRITE;
         xte_pkg::ST_WRITE:
            if (bus_ack_i)
               state_nxt = cont ? xte_pkg::ST_LOAD : xte_pkg::ST_IDLE;
         default:
            state_nxt = xte_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= xte_pkg::ST_IDLE;
         cur_r <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == xte_pkg::ST_IDLE && grant_valid)
            cur_r <= grant;
      end
   end

   // Pending requests; a new event wins over the clear unless en_clr ends the channel
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pend_r <= 8'h00;
      else
         for (int i = 0; i < 8; i++)
            pend_r[i] <= req[i] || (pend_r[i] && ctrl_r[i][xte_pkg::CTL_EN]
                         && !(unit_done && cur_r == 3'(i) && !blk_more
                         && (!auto_c || chan_end)));
   end

   // Bus master outputs
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         bus_req_o <= 1'b0;
         bus_wr_o <= 1'b0;
         bus_word_o <= 1'b0;
         bus_hold_o <= 1'b0;
         bus_addr_o <= xte_pkg::ADDR_RST;
         bus_wdata_o <= 16'h0000;
      end
      else
      begin
         bus_hold_o <= state_nxt != xte_pkg::ST_IDLE;
         if (state_r == xte_pkg::ST_LOAD)
         begin
            bus_req_o <= 1'b1;
            bus_wr_o <= 1'b0;
            bus_word_o <= ctrl_r[full_c ? ca : cur_r][xte_pkg::CTL_WORD];
            bus_addr_o <= src_addr;
         end
         else if (state_r == xte_pkg::ST_READ && bus_ack_i)
         begin
            bus_wr_o <= 1'b1;
            bus_addr_o <= dst_addr;
            bus_wdata_o <= bus_rdata_i;
         end
         else if (unit_done)
         begin
            bus_req_o <= 1'b0;
            bus_wr_o <= 1'b0;
         end
      end
   end

   // Transfer end pins, low for one cycle
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         xfer_end_flag_out_b_o <= 4'hF;
      else
         for (int c = 0; c < 4; c++)
            xfer_end_flag_out_b_o[c] <= !(unit_done && chan_end &&
                                          cur_r[2:1] == 2'(c));
   end

   // Register read, data valid in the next cycle only
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i && hit)
         case (off[2:0])
            xte_pkg::OFS_ADDR_E: reg_rdata_o <= maddr_r[off[5:3]][23:16];
            xte_pkg::OFS_ADDR_H: reg_rdata_o <= maddr_r[off[5:3]][15:8];
            xte_pkg::OFS_ADDR_L: reg_rdata_o <= maddr_r[off[5:3]][7:0];
            xte_pkg::OFS_CNT_H: reg_rdata_o <= count_r[off[5:3]][15:8];
            xte_pkg::OFS_CNT_L: reg_rdata_o <= count_r[off[5:3]][7:0];
            xte_pkg::OFS_IO: reg_rdata_o <= ioaddr_r[off[5:3]];
            xte_pkg::OFS_CTRL: reg_rdata_o <= ctrl_r[off[5:3]];
            default: reg_rdata_o <= 8'h00;
         endcase
      else
         reg_rdata_o <= 8'h00;
   end

   // Channel registers: software writes, then engine updates
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            maddr_r[i] <= xte_pkg::ADDR_RST;
            mbase_r[i] <= xte_pkg::ADDR_RST;
            ioaddr_r[i] <= xte_pkg::IO_RST;
            count_r[i] <= xte_pkg::CNT_RST;
            ctrl_r[i] <= xte_pkg::CTRL_RST;
         end
      end
      else
      begin
         if (reg_wr_i && hit)
            case (off[2:0])
               xte_pkg::OFS_ADDR_E:
               begin
                  maddr_r[off[5:3]][23:16] <= reg_wdata_i;
                  mbase_r[off[5:3]][23:16] <= reg_wdata_i;
               end
               xte_pkg::OFS_ADDR_H:
               begin
                  maddr_r[off[5:3]][15:8] <= reg_wdata_i;
                  mbase_r[off[5:3]][15:8] <= reg_wdata_i;
               end
               xte_pkg::OFS_ADDR_L:
               begin
                  maddr_r[off[5:3]][7:0] <= reg_wdata_i;
                  mbase_r[off[5:3]][7:0] <= reg_wdata_i;
               end
               xte_pkg::OFS_CNT_H: count_r[off[5:3]][15:8] <= reg_wdata_i;
               xte_pkg::OFS_CNT_L: count_r[off[5:3]][7:0] <= reg_wdata_i;
               xte_pkg::OFS_IO: ioaddr_r[off[5:3]] <= reg_wdata_i;
               xte_pkg::OFS_CTRL: ctrl_r[off[5:3]] <= reg_wdata_i;
               default: ;
            endcase
         if (unit_done && !full_c)
         begin
            case (mode_c)
               xte_pkg::MODE_IO:
               begin
                  maddr_r[cur_r] <= step_addr(maddr_r[cur_r],
                     ctrl_r[cur_r][xte_pkg::CTL_WORD],
                     ctrl_r[cur_r][xte_pkg::CTL_DEC]);
                  count_r[cur_r] <= count_r[cur_r] - xte_pkg::CNT_ONE;
               end
               xte_pkg::MODE_REPEAT:
                  if (last_s)
                  begin
                     count_r[cur_r][7:0] <= count_r[cur_r][15:8];
                     maddr_r[cur_r] <= mbase_r[cur_r];
                  end
                  else
                  begin
                     count_r[cur_r][7:0] <= count_r[cur_r][7:0] - 8'h01;
                     maddr_r[cur_r] <= step_addr(maddr_r[cur_r],
                        ctrl_r[cur_r][xte_pkg::CTL_WORD],
                        ctrl_r[cur_r][xte_pkg::CTL_DEC]);
                  end
               default:
                  count_r[cur_r] <= count_r[cur_r] - xte_pkg::CNT_ONE;
            endcase
            if (last_s && mode_c != xte_pkg::MODE_REPEAT)
               ctrl_r[cur_r][xte_pkg::CTL_EN] <= 1'b0;
         end
         else if (unit_done)
         begin
            maddr_r[ca] <= step_addr(maddr_r[ca],
               ctrl_r[ca][xte_pkg::CTL_WORD], ctrl_r[ca][xte_pkg::CTL_DEC]);
            maddr_r[cb] <= step_addr(maddr_r[cb],
               ctrl_r[ca][xte_pkg::CTL_WORD], ctrl_r[cb][xte_pkg::CTL_DEC]);
            if (mode_c == xte_pkg::MODE_BLOCK && blk_last)
            begin
               count_r[ca][7:0] <= count_r[ca][15:8];
               count_r[cb] <= count_r[cb] - xte_pkg::CNT_ONE;
               if (ctrl_r[cb][xte_pkg::CTL_FIXDST])
                  maddr_r[cb] <= mbase_r[cb];
               else
                  maddr_r[ca] <= mbase_r[ca];
            end
            else if (mode_c == xte_pkg::MODE_BLOCK)
               count_r[ca][7:0] <= count_r[ca][7:0] - 8'h01;
            else
               count_r[ca] <= count_r[ca] - xte_pkg::CNT_ONE;
            if (chan_end)
               ctrl_r[ca][xte_pkg::CTL_EN] <= 1'b0;
         end
      end
   end
endmodule : xte_transfer_engine

// ==== xte_monitor.sv ====
/*
 Port checker of the transfer engine.
 Assumes it is bound to xte_transfer_engine on its single clock.
*/
`timescale 1ns/100ps
module xte_monitor (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // End pins
   input wire logic [3:0] xfer_end_flag_out_b_o,
   // System bus
   input wire logic bus_req_o,
   input wire logic bus_wr_o,
   input wire logic bus_word_o,
   input wire logic bus_hold_o,
   input wire logic [23:0] bus_addr_o,
   input wire logic [15:0] bus_wdata_o,
   input wire logic [15:0] bus_rdata_i,
   input wire logic bus_ack_i
);
   logic wr_ack;
   logic [15:0] rcap_r;
   assign wr_ack = bus_req_o && bus_ack_i && bus_wr_o;
   always_ff @(posedge mclk_i)
      rcap_r <= bus_rdata_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_rd_ack;
      bus_req_o && bus_ack_i && !bus_wr_o;
   endsequence
   sequence s_wr_start;
      bus_req_o && bus_wr_o;
   endsequence
   property p_req_hold;
      bus_req_o && !bus_ack_i |=>
         bus_req_o && $stable(bus_addr_o) && $stable(bus_wr_o);
   endproperty
   property p_rd_then_wr;
      s_rd_ack |=> s_wr_start;
   endproperty
   property p_wdata;
      s_rd_ack |=> bus_wdata_o[7:0] == rcap_r[7:0] &&
         (!bus_word_o || bus_wdata_o[15:8] == rcap_r[15:8]);
   endproperty
   property p_wr_release;
      wr_ack |=> !bus_req_o;
   endproperty
   property p_end_cause;
      xfer_end_flag_out_b_o != 4'hF |-> $past(wr_ack);
   endproperty
   property p_end_pulse;
      xfer_end_flag_out_b_o != 4'hF |=> xfer_end_flag_out_b_o == 4'hF;
   endproperty
   property p_hold;
      bus_req_o |-> bus_hold_o;
   endproperty
   property p_rd_unmapped;
      reg_rd_i && (reg_addr_i < 8'h20 || reg_addr_i > 8'h5F) |=>
         reg_rdata_o == 8'h00;
   endproperty
   property p_rd_idle;
      !reg_rd_i |=> reg_rdata_o == 8'h00;
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("bus request changed before ack");
   a_rd_then_wr: assert property (p_rd_then_wr)
      else $error("read not followed by write");
   a_wdata: assert property (p_wdata)
      else $error("write data differs from read data");
   a_wr_release: assert property (p_wr_release)
      else $error("request not released after write");
   a_end_cause: assert property (p_end_cause)
      else $error("end pin without write ack");
   a_end_pulse: assert property (p_end_pulse)
      else $error("end pin longer than one cycle");
   a_hold: assert property (p_hold)
      else $error("request without bus ownership");
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read not zero");
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
endmodule : xte_monitor

bind xte_transfer_engine xte_monitor u_mon (.mclk_i(mclk_i),
   .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .xfer_end_flag_out_b_o(xfer_end_flag_out_b_o),
   .bus_req_o(bus_req_o), .bus_wr_o(bus_wr_o), .bus_word_o(bus_word_o),
   .bus_hold_o(bus_hold_o), .bus_addr_o(bus_addr_o),
   .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
   .bus_ack_i(bus_ack_i));

// ==== xte_bus_mem.sv ====
/*
 Memory and peripheral bus slave facing the transfer engine.
 Assumes the engine holds its request until the one-cycle ack.
*/
`timescale 1ns/100ps
module xte_bus_mem (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Ack delay in cycles
   input wire logic [1:0] lat_i,
   // Bus
   input wire logic req_i,
   input wire logic [23:0] addr_i,
   output logic [15:0] rdata_o,
   output logic ack_o
);
   logic [1:0] wait_r;
   logic [15:0] last_r;
   // Released data lines show the inverse of the last value
   assign rdata_o = ack_o ? {addr_i[7:0] ^ 8'h5A, addr_i[7:0]} : ~last_r;
   always_ff @(posedge mclk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         wait_r <= 2'h0;
         ack_o <= 1'b0;
         last_r <= 16'h0000;
      end
      else if (ack_o)
      begin
         ack_o <= 1'b0;
         wait_r <= 2'h0;
         last_r <= rdata_o;
      end
      else if (req_i && wait_r >= lat_i)
         ack_o <= 1'b1;
      else if (req_i)
         wait_r <= wait_r + 2'h1;
endmodule : xte_bus_mem

// ==== tb_xte_transfer_engine.sv ====
/*
 Self-checking bench of the transfer engine.
 Assumes the bus slave model answers every bus cycle.
*/
`timescale 1ns/100ps
module tb_xte_transfer_engine;
   logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, bus_req_o, bus_wr_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [3:0] tmr_match_i, ext_b, end_b;
   logic sci_tx_empty_i, sci_rx_full_i, bus_word_o, bus_hold_o, bus_ack_i;
   logic [23:0] bus_addr_o, m, d;
   logic [15:0] bus_wdata_o, bus_rdata_i;
   logic [1:0] lat;
   logic [25:0] q_bus[$];
   logic [7:0] q_rd[$];
   logic rd_pend, hold_q;
   int err_total, n_compared, seed, ends[4], drops, d0;
   xte_transfer_engine uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .tmr_match_i(tmr_match_i), .sci_tx_empty_i(sci_tx_empty_i),
      .sci_rx_full_i(sci_rx_full_i), .ext_xfer_request_b_i(ext_b),
      .xfer_end_flag_out_b_o(end_b), .bus_req_o(bus_req_o),
      .bus_wr_o(bus_wr_o), .bus_word_o(bus_word_o), .bus_hold_o(bus_hold_o),
      .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
      .bus_rdata_i(bus_rdata_i), .bus_ack_i(bus_ack_i));
   xte_bus_mem u_mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .lat_i(lat),
      .req_i(bus_req_o), .addr_i(bus_addr_o), .rdata_o(bus_rdata_i),
      .ack_o(bus_ack_i));
   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic chk(string nm, logic [25:0] e, logic [25:0] s);
      n_compared++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic chk_reg(logic [7:0] e, logic [7:0] s);
      chk("reg_rdata_o", 26'(e), 26'(s));
   endtask : chk_reg
   task automatic chk_bus(logic [25:0] e, logic [25:0] s);
      chk("bus cycle", e, s);
   endtask : chk_bus
   task automatic chk_cnt(string nm, logic [25:0] e, logic [25:0] s);
      chk(nm, e, s);
   endtask : chk_cnt
   task automatic close_out;
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      q_rd.push_back(e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
   endtask : rd
   task automatic prog(int s, logic [23:0] a, logic [15:0] c,
                       logic [7:0] io, logic [7:0] ct);
      logic [55:0] v;
      v = {a, c, io, ct};
      for (int k = 1; k < 8; k++)
         wr(8'h20 + 8'(s * 8 + k), v[63 - 8 * k -: 8]);
   endtask : prog
   task automatic unit(logic [23:0] s, logic [23:0] t, logic w);
      q_bus.push_back({w, 1'b0, s});
      q_bus.push_back({w, 1'b1, t});
   endtask : unit
   task automatic pulse(logic [5:0] e);
      @(posedge mclk_i);
      {sci_rx_full_i, sci_tx_empty_i, tmr_match_i} <= e;
      lat <= 2'($random(seed));
      @(posedge mclk_i);
      {sci_rx_full_i, sci_tx_empty_i, tmr_match_i} <= 6'h00;
   endtask : pulse
   task automatic ext(int k);
      @(posedge mclk_i);
      ext_b[k] <= 1'b0;
      repeat (4) @(posedge mclk_i);
      ext_b[k] <= 1'b1;
   endtask : ext
   task automatic settle;
      int n;
      n = 0;
      while ((q_bus.size() != 0 || bus_hold_o !== 1'b0) && n < 500)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 500)
      begin
         err_total++;
         close_out;
      end
      repeat (12) @(posedge mclk_i);
   endtask : settle
   always @(negedge mclk_i)
   begin
      logic [25:0] eb;
      if (rd_pend)
         chk_reg(q_rd.pop_front(), reg_rdata_o);
      rd_pend = reg_rd_i;
      if (bus_req_o && bus_ack_i)
      begin
         eb = q_bus.size() ? q_bus.pop_front() : 26'h3FFFFFF;
         chk_bus(eb, {bus_word_o, bus_wr_o, bus_addr_o});
      end
      for (int k = 0; k < 4; k++)
         if (end_b[k] === 1'b0)
            ends[k]++;
      if (hold_q === 1'b1 && bus_hold_o === 1'b0)
         drops++;
      hold_q = bus_hold_o;
   end
   initial
   begin
      {rst_b_i, reg_wr_i, reg_rd_i, rd_pend} = 4'h0;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      {sci_rx_full_i, sci_tx_empty_i, tmr_match_i} = 6'h00;
      ext_b = 4'hF;
      lat = 2'h0;
      seed = 86574;
      m = {8'h12, 15'($random(seed)), 1'b0};
      d = m + 24'h400000;
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(8'h27, 8'h00);
      rd(8'h10, 8'h00);
      rd(8'h60, 8'h00);
      wr(8'h23, 8'hA5);
      rd(8'h23, 8'hA5);
      rd(8'h20, 8'h00);
      prog(2, m, 16'h0002, 8'h3C, 8'hE0);
      unit(m, 24'hFFFF3C, 1'b1);
      pulse(6'h02);
      settle();
      unit(m - 24'h2, 24'hFFFF3C, 1'b1);
      pulse(6'h02);
      settle();
      pulse(6'h02);
      settle();
      prog(0, m, 16'h0001, 8'h11, 8'h83);
      ext(0);
      settle();
      prog(1, m, 16'h0202, 8'h44, 8'h88);
      for (int i = 0; i < 3; i++)
      begin
         unit(i == 1 ? m + 24'h1 : m, 24'hFFFF44, 1'b0);
         pulse(6'h01);
         settle();
      end
      prog(4, m, 16'h0002, 8'h55, 8'h85);
      prog(5, m + 24'h100, 16'h0002, 8'h66, 8'h85);
      for (int i = 0; i < 2; i++)
      begin
         unit(m, 24'hFFFF55, 1'b0);
         unit(m + 24'h100, 24'hFFFF66, 1'b0);
         pulse(6'h10);
         settle();
      end
      prog(6, m, 16'h0001, 8'h77, 8'h82);
      unit(24'hFFFF77, m, 1'b0);
      pulse(6'h20);
      settle();
      prog(7, m, 16'h0001, 8'h78, 8'h83);
      unit(m, 24'hFFFF78, 1'b0);
      ext(3);
      settle();
      for (int j = 0; j < 2; j++)
      begin
         prog(3, d, 16'h0000, 8'h00, 8'h00);
         unit(m, d, 1'b0);
         unit(m + 24'h1, d + 24'h1, 1'b0);
         d0 = drops;
         prog(2, m, 16'h0002, 8'h00, j ? 8'h91 : 8'h92);
         settle();
         chk_cnt("hold drops", j ? 26'h2 : 26'h1, 26'(drops - d0));
      end
      prog(3, d, 16'h0002, 8'h00, 8'h10);
      prog(2, m, 16'h0202, 8'h00, 8'h94);
      for (int b = 0; b < 2; b++)
      begin
         unit(m + 24'(2 * b), d, 1'b0);
         unit(m + 24'(2 * b + 1), d + 24'h1, 1'b0);
         pulse(6'h02);
         settle();
      end
      chk_cnt("end pin 0", 26'h1, 26'(ends[0]));
      chk_cnt("end pin 1", 26'h4, 26'(ends[1]));
      chk_cnt("end pin 2", 26'h2, 26'(ends[2]));
      chk_cnt("end pin 3", 26'h2, 26'(ends[3]));
      close_out();
   end
endmodule : tb_xte_transfer_engine
